// *** dds_dft_pkg.sv ***
// Constants, register map and carrier types for the excitation and DFT core
`default_nettype none

package dds_dft_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DEVICE_CONTROL = 8'h81;
    localparam logic [7:0] ADDR_FREQ_INC_HI    = 8'h82;
    localparam logic [7:0] ADDR_FREQ_INC_MID   = 8'h83;
    localparam logic [7:0] ADDR_FREQ_INC_LO    = 8'h84;
    localparam logic [7:0] ADDR_STATUS         = 8'h8F;
    localparam logic [7:0] ADDR_REAL_HI        = 8'h94;
    localparam logic [7:0] ADDR_REAL_LO        = 8'h95;
    localparam logic [7:0] ADDR_IMAG_HI        = 8'h96;
    localparam logic [7:0] ADDR_IMAG_LO        = 8'h97;

    localparam logic [7:0] CONTROL_RESET       = 8'h00;
    localparam logic [7:0] FREQ_INC_RESET      = 8'h00;
    localparam int         BIT_START           = 0;
    localparam int         BIT_EXT_CLOCK_SEL   = 3;
    localparam int         BIT_STAT_BUSY       = 0;
    localparam int         BIT_STAT_DONE       = 1;
    localparam int         BIT_STAT_OVERRUN    = 2;

    // ------------------------------------------------------------------
    // Datapath sizes and clock division
    // ------------------------------------------------------------------
    localparam int PHASE_W      = 27;
    localparam int PHASE_ZERO_W = 3;
    localparam int PHASE_LIVE_W = PHASE_W - PHASE_ZERO_W;
    localparam int ROM_ADDR_W   = 5;
    localparam int ROM_DATA_W   = 10;
    localparam int ADC_W        = 12;
    localparam int ACC_W        = 36;
    localparam int RESULT_W     = 16;
    localparam int RESULT_SHIFT = 16;

    localparam logic [3:0] DDS_DIV_LAST  = 4'hF;
    localparam logic [1:0] ADC_DIV_LAST  = 2'h3;
    localparam logic [3:0] CONV_LAST     = 4'hF;
    localparam logic [4:0] COS_OFFSET    = 5'h08;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ROM_ADDR_W-1:0] phase;
        logic [ADC_W-1:0]      code;
    } sample_t;

    typedef enum logic [1:0] {
        MEAS_IDLE,
        MEAS_ACQUIRE,
        MEAS_STORE
    } meas_state_t;

endpackage

`default_nettype wire

// *** dds_excitation_dft_core.sv ***
// Excitation synthesizer, sample buffer and single-point DFT engine
//
// What this block does
// - Hold a 27-bit phase accumulator.
// - Accumulator output addresses the sine look-up ROM.
// - ROM holds one full sine cycle.
// - ROM word drives the excitation DAC code.
// - Accumulator, ROM, DAC share one system clock.
// - Control bit D3 selects external clock operation.
// - Sample rate is system clock over 64.
// - One conversion takes sixteen ADC clock periods.
// - Collect 1024 samples, pass to multiply-accumulate.
// - Compute 1024-point DFT over collected samples.
// - Sample rate scales with system clock.
// - DFT inputs are 12-bit ADC words.
// - Test phasor from excitation phase at each sample.
// - Correlate at the current excitation frequency.
// - Top three accumulator bits tied to zero.
// - DDS reference clk/16, ADC clock clk/4.
// - Store real at 94h/95h, imaginary 96h/97h.
`timescale 1ns/1ns
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire  logic             clk_sys_in,
    input  wire  logic             srst_in,
    // Fill side
    input  wire  logic             wr_valid_in,
    output logic                   wr_ready_out,
    input  wire  logic [WIDTH-1:0] wr_data_in,
    // Drain side
    output logic                   rd_valid_out,
    input  wire  logic             rd_ready_in,
    output logic [WIDTH-1:0]       rd_data_out
);
    localparam int PTR_W = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
            $error("sample_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W:0]   wr_ptr_q;
    logic [PTR_W:0]   rd_ptr_q;
    wire              full_w  = (wr_ptr_q[PTR_W] != rd_ptr_q[PTR_W]) &&
                                (wr_ptr_q[PTR_W-1:0] == rd_ptr_q[PTR_W-1:0]);
    wire              empty_w = (wr_ptr_q == rd_ptr_q);
    wire              push_w  = wr_valid_in && !full_w;
    wire              pop_w   = rd_ready_in && !empty_w;

    assign wr_ready_out = !full_w;
    assign rd_valid_out = !empty_w;
    assign rd_data_out  = mem[rd_ptr_q[PTR_W-1:0]];

    always_ff @(posedge clk_sys_in) begin
        if (push_w) begin
            mem[wr_ptr_q[PTR_W-1:0]] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + (PTR_W+1)'(push_w);
            rd_ptr_q <= rd_ptr_q + (PTR_W+1)'(pop_w);
        end
    end
endmodule

module dds_excitation_dft_core
    import dds_dft_pkg::*;
#(
    parameter int SAMPLE_COUNT = 1024,
    parameter int FIFO_DEPTH   = 8
) (
    // Clock and reset
    input  wire  logic                  clk_sys_in,
    input  wire  logic                  srst_in,
    // Register port
    input  wire  logic [7:0]            reg_addr_in,
    input  wire  logic [7:0]            reg_wdata_in,
    input  wire  logic                  reg_wr_in,
    input  wire  logic                  reg_rd_in,
    output logic [7:0]                  reg_rdata_out,
    // Excitation DAC
    output logic [ROM_DATA_W-1:0]       excitation_out,
    output logic                        dac_update_out,
    // Response ADC
    output logic                        adc_convst_out,
    input  wire  logic [ADC_W-1:0]      adc_data_in,
    // Status pins
    output logic                        ext_clock_select_out,
    output logic                        meas_done_out
);
    localparam int CNT_W = $clog2(SAMPLE_COUNT) + 1;

    generate
        if (SAMPLE_COUNT < 2 || (1 << (CNT_W-1)) != SAMPLE_COUNT) begin : g_bad_count
            $error("SAMPLE_COUNT must be a power of two of at least 2");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Sine table
    // ------------------------------------------------------------------
    // Quarter wave with symmetry gives the whole cycle in 32 points.
    function automatic logic signed [ROM_DATA_W-1:0] quarter_sine(input logic [3:0] idx);
        case (idx)
            4'h0:    quarter_sine = 10'sh000;
            4'h1:    quarter_sine = 10'sh064;
            4'h2:    quarter_sine = 10'sh0C4;
            4'h3:    quarter_sine = 10'sh11C;
            4'h4:    quarter_sine = 10'sh169;
            4'h5:    quarter_sine = 10'sh1A9;
            4'h6:    quarter_sine = 10'sh1D8;
            4'h7:    quarter_sine = 10'sh1F5;
            default: quarter_sine = 10'sh1FF;
        endcase
    endfunction

    function automatic logic signed [ROM_DATA_W-1:0] sine_rom(input logic [ROM_ADDR_W-1:0] a);
        logic [3:0]                   idx;
        logic signed [ROM_DATA_W-1:0] mag;
        idx = a[3] ? (4'h8 - {1'b0, a[2:0]}) : {1'b0, a[2:0]};
        mag = quarter_sine(idx);
        sine_rom = a[4] ? -mag : mag;
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]                control_q;
    logic [PHASE_LIVE_W-1:0]   freq_inc_q;
    logic                      done_q;
    logic                      overrun_q;
    logic [RESULT_W-1:0]       real_q;
    logic [RESULT_W-1:0]       imag_q;
    logic [7:0]                rdata_q;
    meas_state_t               state_q;

    wire run_w       = control_q[BIT_EXT_CLOCK_SEL];
    wire wr_ctrl_w   = reg_wr_in && (reg_addr_in == ADDR_DEVICE_CONTROL);
    wire wr_stat_w   = reg_wr_in && (reg_addr_in == ADDR_STATUS);
    wire start_w     = wr_ctrl_w && reg_wdata_in[BIT_START] && (state_q == MEAS_IDLE);
    wire store_w     = (state_q == MEAS_STORE);
    wire done_clr_w  = wr_stat_w && reg_wdata_in[BIT_STAT_DONE];
    wire ovr_clr_w   = wr_stat_w && reg_wdata_in[BIT_STAT_OVERRUN];
    wire overrun_w;

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            control_q  <= CONTROL_RESET;
            freq_inc_q <= {3{FREQ_INC_RESET}};
        end else if (reg_wr_in) begin
            if (reg_addr_in == ADDR_DEVICE_CONTROL) begin
                control_q <= reg_wdata_in & ~(8'h01 << BIT_START);
            end else if (reg_addr_in == ADDR_FREQ_INC_HI) begin
                freq_inc_q[23:16] <= reg_wdata_in;
            end else if (reg_addr_in == ADDR_FREQ_INC_MID) begin
                freq_inc_q[15:8] <= reg_wdata_in;
            end else if (reg_addr_in == ADDR_FREQ_INC_LO) begin
                freq_inc_q[7:0] <= reg_wdata_in;
            end
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            done_q    <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            done_q    <= store_w || (done_q && !done_clr_w);
            overrun_q <= overrun_w || (overrun_q && !ovr_clr_w);
        end
    end

    wire [7:0] status_w = {5'h00, overrun_q, done_q, (state_q != MEAS_IDLE)};

    wire [7:0] rd_mux_w =
        (reg_addr_in == ADDR_DEVICE_CONTROL) ? control_q :
        (reg_addr_in == ADDR_FREQ_INC_HI)    ? freq_inc_q[23:16] :
        (reg_addr_in == ADDR_FREQ_INC_MID)   ? freq_inc_q[15:8] :
        (reg_addr_in == ADDR_FREQ_INC_LO)    ? freq_inc_q[7:0] :
        (reg_addr_in == ADDR_STATUS)         ? status_w :
        (reg_addr_in == ADDR_REAL_HI)        ? real_q[15:8] :
        (reg_addr_in == ADDR_REAL_LO)        ? real_q[7:0] :
        (reg_addr_in == ADDR_IMAG_HI)        ? imag_q[15:8] :
        (reg_addr_in == ADDR_IMAG_LO)        ? imag_q[7:0] : 8'h00;

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_in) begin
            rdata_q <= rd_mux_w;
        end
    end

    assign reg_rdata_out        = rdata_q;
    assign ext_clock_select_out = run_w;
    assign meas_done_out        = done_q;

    // ------------------------------------------------------------------
    // Clock dividers
    // ------------------------------------------------------------------
    // All rates derive from the one system clock, so lowering it lowers
    // the sample rate in step.
    logic [3:0] dds_div_q;
    logic [1:0] adc_div_q;
    logic [3:0] conv_q;

    wire dds_tick_w    = run_w && (dds_div_q == DDS_DIV_LAST);
    wire adc_tick_w    = run_w && (adc_div_q == ADC_DIV_LAST);
    wire sample_tick_w = adc_tick_w && (conv_q == CONV_LAST);

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            dds_div_q <= '0;
            adc_div_q <= '0;
            conv_q    <= '0;
        end else if (run_w) begin
            dds_div_q <= dds_div_q + 4'h1;
            adc_div_q <= adc_div_q + 2'h1;
            if (adc_tick_w) begin
                conv_q <= conv_q + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Phase accumulator, ROM and DAC
    // ------------------------------------------------------------------
    logic [PHASE_W-1:0] phase_q;
    logic               dac_upd_q;

    wire [PHASE_LIVE_W-1:0] phase_sum_w = phase_q[PHASE_LIVE_W-1:0] + freq_inc_q;
    wire [ROM_ADDR_W-1:0]   rom_addr_w  =
        phase_q[PHASE_LIVE_W-1 -: ROM_ADDR_W];
    wire signed [ROM_DATA_W-1:0] rom_sin_w = sine_rom(rom_addr_w);

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            phase_q        <= '0;
            excitation_out <= '0;
            dac_upd_q      <= 1'b0;
        end else begin
            dac_upd_q <= dds_tick_w;
            if (dds_tick_w) begin
                phase_q        <= {{PHASE_ZERO_W{1'b0}}, phase_sum_w};
                excitation_out <= {~rom_sin_w[ROM_DATA_W-1], rom_sin_w[ROM_DATA_W-2:0]};
            end
        end
    end

    assign dac_update_out = dac_upd_q;

    // ------------------------------------------------------------------
    // ADC capture
    // ------------------------------------------------------------------
    logic [ADC_W-1:0] adc_meta_q;
    logic [ADC_W-1:0] adc_sync_q;
    logic             convst_q;

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            adc_meta_q <= '0;
            adc_sync_q <= '0;
            convst_q   <= 1'b0;
        end else begin
            adc_meta_q <= adc_data_in;
            adc_sync_q <= adc_meta_q;
            convst_q   <= adc_tick_w && (conv_q == 4'h0);
        end
    end

    assign adc_convst_out = convst_q;

    // ------------------------------------------------------------------
    // Acquisition and sample buffer
    // ------------------------------------------------------------------
    // Each sample carries the excitation phase at its own instant, so the
    // correlation always follows the tone being generated.
    logic [CNT_W-1:0] acq_cnt_q;
    logic [CNT_W-1:0] mac_cnt_q;
    logic             fifo_wr_ready;
    logic             fifo_rd_valid;
    sample_t          fifo_rd_data;
    sample_t          wr_sample_w;

    assign wr_sample_w.phase = rom_addr_w;
    assign wr_sample_w.code  = adc_sync_q;

    wire acquiring_w = (state_q == MEAS_ACQUIRE) && (acq_cnt_q != CNT_W'(SAMPLE_COUNT));
    wire push_w      = sample_tick_w && acquiring_w;
    // A full buffer loses the sample; the count waits for an accepted one
    assign overrun_w = push_w && !fifo_wr_ready;
    wire accepted_w  = push_w && fifo_wr_ready;
    wire mac_ready_w = (state_q == MEAS_ACQUIRE);
    wire mac_take_w  = mac_ready_w && fifo_rd_valid;

    sample_fifo #(
        .WIDTH ($bits(sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in   (clk_sys_in),
        .srst_in      (srst_in),
        .wr_valid_in  (push_w),
        .wr_ready_out (fifo_wr_ready),
        .wr_data_in   (wr_sample_w),
        .rd_valid_out (fifo_rd_valid),
        .rd_ready_in  (mac_ready_w),
        .rd_data_out  (fifo_rd_data)
    );

    // ------------------------------------------------------------------
    // Multiply-accumulate
    // ------------------------------------------------------------------
    // Offset-binary ADC codes become signed so the DC term cancels.
    wire signed [ADC_W-1:0]      x_w   = {~fifo_rd_data.code[ADC_W-1],
                                          fifo_rd_data.code[ADC_W-2:0]};
    wire signed [ROM_DATA_W-1:0] cos_w = sine_rom(fifo_rd_data.phase + COS_OFFSET);
    wire signed [ROM_DATA_W-1:0] sin_w = sine_rom(fifo_rd_data.phase);
    wire signed [ADC_W+ROM_DATA_W-1:0] prod_re_w = x_w * cos_w;
    wire signed [ADC_W+ROM_DATA_W-1:0] prod_im_w = x_w * sin_w;

    logic signed [ACC_W-1:0] acc_re_q;
    logic signed [ACC_W-1:0] acc_im_q;

    always_ff @(posedge clk_sys_in) begin
        if (srst_in || start_w) begin
            acc_re_q  <= '0;
            acc_im_q  <= '0;
            mac_cnt_q <= '0;
        end else if (mac_take_w) begin
            acc_re_q  <= acc_re_q + ACC_W'(prod_re_w);
            acc_im_q  <= acc_im_q - ACC_W'(prod_im_w);
            mac_cnt_q <= mac_cnt_q + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Measurement sequence
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_q   <= MEAS_IDLE;
            acq_cnt_q <= '0;
            real_q    <= '0;
            imag_q    <= '0;
        end else begin
            case (state_q)
                MEAS_IDLE: begin
                    if (start_w) begin
                        acq_cnt_q <= '0;
                        state_q   <= MEAS_ACQUIRE;
                    end
                end
                MEAS_ACQUIRE: begin
                    if (accepted_w) begin
                        acq_cnt_q <= acq_cnt_q + CNT_W'(1);
                    end
                    if (mac_cnt_q == CNT_W'(SAMPLE_COUNT)) begin
                        state_q <= MEAS_STORE;
                    end
                end
                MEAS_STORE: begin
                    real_q  <= acc_re_q[RESULT_SHIFT+RESULT_W-1:RESULT_SHIFT];
                    imag_q  <= acc_im_q[RESULT_SHIFT+RESULT_W-1:RESULT_SHIFT];
                    state_q <= MEAS_IDLE;
                end
                default: begin
                    state_q <= MEAS_IDLE;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// *** adc_response_model.sv ***
// Behavioural response ADC that answers the core's conversion-start pulses
`timescale 1ns/1ns
`default_nettype none

module adc_response_model
    import dds_dft_pkg::*;
#(
    parameter logic [ADC_W-1:0] CODE = 12'h800
) (
    // Clock
    input  wire  logic             clk_sys_in,
    // Converter handshake
    input  wire  logic             adc_convst_in,
    output logic [ADC_W-1:0]       adc_data_out
);
    int age = 0;

    // Result is meaningless while converting, so it churns every cycle
    always_ff @(posedge clk_sys_in) begin
        if (adc_convst_in) begin
            age <= 0;
        end else if (age < 1000) begin
            age <= age + 1;
        end
        if (age >= 16 && !adc_convst_in) begin
            adc_data_out <= CODE;
        end else begin
            adc_data_out <= adc_data_out + 12'h3A5;
        end
    end
endmodule

`default_nettype wire

// *** dds_core_assertions.sv ***
// Port-level checker for the excitation and DFT core
`timescale 1ns/1ns
`default_nettype none

module dds_core_checker
    import dds_dft_pkg::*;
(
    // Clock and reset
    input  wire  logic                  clk_sys_in,
    input  wire  logic                  srst_in,
    // Register port
    input  wire  logic [7:0]            reg_addr_in,
    input  wire  logic [7:0]            reg_wdata_in,
    input  wire  logic                  reg_wr_in,
    input  wire  logic                  reg_rd_in,
    input  wire  logic [7:0]            reg_rdata_out,
    // Converters and status
    input  wire  logic [ROM_DATA_W-1:0] excitation_out,
    input  wire  logic                  dac_update_out,
    input  wire  logic                  adc_convst_out,
    input  wire  logic [ADC_W-1:0]      adc_data_in,
    input  wire  logic                  ext_clock_select_out,
    input  wire  logic                  meas_done_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    // Spacing is judged only within one undisturbed run
    logic [5:0] conv_gap_q;
    logic [3:0] dac_gap_q;
    logic       conv_seen_q;
    logic       dac_seen_q;
    wire        ctrl_wr = reg_wr_in && reg_addr_in == ADDR_DEVICE_CONTROL;
    wire        stat_clr = reg_wr_in && reg_addr_in == ADDR_STATUS && reg_wdata_in[BIT_STAT_DONE];
    wire        mapped = (reg_addr_in >= 8'h81 && reg_addr_in <= 8'h84)
                      || reg_addr_in == ADDR_STATUS
                      || (reg_addr_in >= 8'h94 && reg_addr_in <= 8'h97);
    wire        stop_seen = srst_in || ctrl_wr || !ext_clock_select_out;

    always_ff @(posedge clk_sys_in) begin
        conv_gap_q  <= adc_convst_out ? 6'h00 : conv_gap_q + 6'h01;
        dac_gap_q   <= dac_update_out ? 4'h0 : dac_gap_q + 4'h1;
        conv_seen_q <= stop_seen ? 1'b0 : (conv_seen_q || adc_convst_out);
        dac_seen_q  <= stop_seen ? 1'b0 : (dac_seen_q || dac_update_out);
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_conv_gap_exact: assert property (adc_convst_out && conv_seen_q |-> conv_gap_q == 6'h3F)
        else $error("conversion start spacing is not 64 clocks");
    a_conv_rate_kept: assert property (conv_seen_q && ext_clock_select_out && !ctrl_wr && conv_gap_q == 6'h3F |-> adc_convst_out)
        else $error("conversion start missing after 64 clocks");
    a_dac_gap_exact: assert property (dac_update_out && dac_seen_q |-> dac_gap_q == 4'hF)
        else $error("DAC update spacing is not 16 clocks");
    a_dac_rate_kept: assert property (dac_seen_q && ext_clock_select_out && !ctrl_wr && dac_gap_q == 4'hF |-> dac_update_out)
        else $error("DAC update missing after 16 clocks");
    a_stop_quiet: assert property (!ext_clock_select_out && $past(!ext_clock_select_out) |-> !adc_convst_out && !dac_update_out)
        else $error("converter pulses while clock run is off");
    a_code_holds: assert property (!dac_update_out |-> $stable(excitation_out))
        else $error("DAC code changed without an update pulse");
    a_ext_follows: assert property (ctrl_wr |=> ext_clock_select_out == $past(reg_wdata_in[BIT_EXT_CLOCK_SEL]))
        else $error("clock select output does not follow control write");
    a_ctrl_readback: assert property (reg_rd_in && reg_addr_in == ADDR_DEVICE_CONTROL |=> reg_rdata_out[3] == ext_clock_select_out && !reg_rdata_out[0])
        else $error("control read back wrong");
    a_unmapped_zero: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data changed without a read");
    a_done_sticky: assert property (meas_done_out && !stat_clr |=> meas_done_out)
        else $error("done flag dropped without a clear");
endmodule

bind dds_excitation_dft_core dds_core_checker u_checker (
    .clk_sys_in           (clk_sys_in),
    .srst_in              (srst_in),
    .reg_addr_in          (reg_addr_in),
    .reg_wdata_in         (reg_wdata_in),
    .reg_wr_in            (reg_wr_in),
    .reg_rd_in            (reg_rd_in),
    .reg_rdata_out        (reg_rdata_out),
    .excitation_out       (excitation_out),
    .dac_update_out       (dac_update_out),
    .adc_convst_out       (adc_convst_out),
    .adc_data_in          (adc_data_in),
    .ext_clock_select_out (ext_clock_select_out),
    .meas_done_out        (meas_done_out)
);

`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the excitation and DFT core
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import dds_dft_pkg::*;

    localparam int             SAMPLES  = 16;
    localparam logic [ADC_W-1:0] ADC_CODE = 12'h900;

    logic                  clk_sys_in   = 1'b0;
    logic                  srst_in      = 1'b1;
    logic [7:0]            reg_addr_in  = 8'h00;
    logic [7:0]            reg_wdata_in = 8'h00;
    logic                  reg_wr_in    = 1'b0;
    logic                  reg_rd_in    = 1'b0;
    logic [7:0]            reg_rdata_out;
    logic [ROM_DATA_W-1:0] excitation_out;
    logic                  dac_update_out;
    logic                  adc_convst_out;
    logic [ADC_W-1:0]      adc_data_in;
    logic                  ext_clock_select_out;
    logic                  meas_done_out;
    int                    miscompares = 0;
    int                    comparisons = 0;
    int                    n_conv;
    int                    n_dac;
    logic [7:0]            zero_addrs [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h8F,
                                               8'h94, 8'h95, 8'h96, 8'h97, 8'h90};

    always #2 clk_sys_in = ~clk_sys_in;

    dds_excitation_dft_core #(.SAMPLE_COUNT(SAMPLES), .FIFO_DEPTH(8)) u_dut (
        .clk_sys_in           (clk_sys_in),
        .srst_in              (srst_in),
        .reg_addr_in          (reg_addr_in),
        .reg_wdata_in         (reg_wdata_in),
        .reg_wr_in            (reg_wr_in),
        .reg_rd_in            (reg_rd_in),
        .reg_rdata_out        (reg_rdata_out),
        .excitation_out       (excitation_out),
        .dac_update_out       (dac_update_out),
        .adc_convst_out       (adc_convst_out),
        .adc_data_in          (adc_data_in),
        .ext_clock_select_out (ext_clock_select_out),
        .meas_done_out        (meas_done_out)
    );

    adc_response_model #(.CODE(ADC_CODE)) u_adc (
        .clk_sys_in    (clk_sys_in),
        .adc_convst_in (adc_convst_out),
        .adc_data_out  (adc_data_in)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        #1;
        reg_addr_in  = a;
        reg_wdata_in = d;
        reg_wr_in    = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_wr_in = 1'b0;
    endtask

    task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        #1;
        reg_addr_in = a;
        reg_rd_in   = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_rd_in = 1'b0;
        check(reg_rdata_out, exp);
    endtask

    task automatic do_reset();
        srst_in = 1'b1;
        repeat (12) @(posedge clk_sys_in);
        #1;
        srst_in = 1'b0;
    endtask

    task automatic tally(input int cycles);
        n_conv = 0;
        n_dac  = 0;
        repeat (cycles) begin
            @(posedge clk_sys_in);
            #1;
            if (adc_convst_out === 1'b1) n_conv++;
            if (dac_update_out === 1'b1) n_dac++;
        end
    endtask

    function automatic logic [15:0] sine_code(input int k);
        int q [9] = '{0, 100, 196, 284, 361, 425, 472, 501, 511};
        int i;
        int a;
        i = k % 32;
        a = (i % 16) <= 8 ? q[i % 16] : q[16 - (i % 16)];
        return 16'(512 + (i < 16 ? a : -a));
    endfunction

    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #80000;
        miscompares++;
        test_done();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        do_reset();
        check({meas_done_out, ext_clock_select_out, dac_update_out, adc_convst_out}, 16'h0000);
        foreach (zero_addrs[i]) read_check(zero_addrs[i], 8'h00);
        reg_write(ADDR_FREQ_INC_HI, 8'h08);
        read_check(ADDR_FREQ_INC_HI, 8'h08);
        reg_write(ADDR_REAL_HI, 8'hFF);
        read_check(ADDR_REAL_HI, 8'h00);
        reg_write(8'h90, 8'h55);
        read_check(8'h90, 8'h00);
        reg_write(ADDR_DEVICE_CONTROL, 8'h08);
        for (int k = 0; k < 40; k++) begin
            for (int w = 0; w < 40 && dac_update_out !== 1'b1; w++) begin
                @(posedge clk_sys_in);
                #1;
            end
            check(excitation_out, sine_code(k));
            @(posedge clk_sys_in);
            #1;
        end
        tally(640);
        check(n_conv, 10);
        check(n_dac, 40);
        read_check(ADDR_DEVICE_CONTROL, 8'h08);
        reg_write(ADDR_DEVICE_CONTROL, 8'h00);
        check(ext_clock_select_out, 1'b0);
        tally(200);
        check(n_conv + n_dac, 0);
        do_reset();
        reg_write(ADDR_DEVICE_CONTROL, 8'h08);
        reg_write(ADDR_DEVICE_CONTROL, 8'h09);
        read_check(ADDR_STATUS, 8'h01);
        reg_write(ADDR_DEVICE_CONTROL, 8'h09);
        for (int w = 0; w < SAMPLES * 64 + 600 && meas_done_out !== 1'b1; w++) begin
            @(posedge clk_sys_in);
            #1;
        end
        read_check(ADDR_STATUS, 8'h02);
        read_check(ADDR_REAL_HI, 8'h00);
        read_check(ADDR_REAL_LO, 8'h1F);
        read_check(ADDR_IMAG_HI, 8'h00);
        read_check(ADDR_IMAG_LO, 8'h00);
        reg_write(ADDR_STATUS, 8'h02);
        read_check(ADDR_STATUS, 8'h00);
        check(meas_done_out, 1'b0);
        test_done();
    end
endmodule

`default_nettype wire
